// [sim/ots_load.sv]
// Load model wired to the collector and relay terminals
module ots_load (
	input  logic mclk,
	input  logic collectorOut,
	input  logic relayOut,
	output logic colLevel,
	output logic relayContact
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up on the collector line, so a conducting transistor reads low
	assign colLevel = !collectorOut;
	// Armature lags the coil a cycle, so chatter is never seen sooner
	always @(posedge mclk) begin
		relayContact <= relayOut;
	end
endmodule

// [sim/ots_selector_bench.sv]
// Self-checking bench of the output terminal selector
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ots_selector_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst, runCmd, dcBrake, faultTrip, faultReset, resetDone, startPossible;
	logic        pidActive, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [15:0] outFreq, thermalAcc, heatsinkTemp, outCurrent, avgCurrent, maintTimer;
	logic        reverseRun;
	logic [15:0] brakeDuty;
	logic [7:0]  flagIn, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, d;
	logic [1:0]  r;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         collectorOut, relayOut, thermalTrip, colLevel, relayContact;
	int          errors, cmp_count;
	// ****************************************
	// Design and load
	// ****************************************
	ots_selector #(.PULSE_UNIT(16'h0004)) ots_selector_inst (.mclk, .rst, .outFreq,
		.setFreq(16'h0040), .runCmd, .reverseRun, .dcBrake, .stallActive(flagIn[0]),
		.brakeDuty, .thermalAcc, .heatsinkTemp, .heatsinkLimit(16'h0064),
		.outCurrent, .outPower(16'h0000), .pidActive, .feedbackLow(flagIn[4]),
		.feedbackHigh(flagIn[5]), .pidForward(flagIn[6]), .pidPause(flagIn[2]),
		.powerlossDecel(flagIn[7]), .powerlossRelease(faultReset), .retryActive(flagIn[1]),
		.internalFault(flagIn[3]), .faultTrip, .faultReset, .resetDone, .startPossible,
		.avgCurrent, .maintTimer, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .collectorOut,
		.relayOut, .thermalTrip);
	ots_load ots_load_inst (.mclk, .collectorOut, .relayOut, .colLevel, .relayContact);
	// ****************************************
	// Bus and timing helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Extra edge at the end keeps two writes from touching a strobe in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		// Ready comes a cycle late so the slave must hold its response
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n >= 50) errors++;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		// Late ready makes the slave hold read data a cycle
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (n >= 50) errors++;
		@(posedge mclk);
	endtask
	task report_and_stop;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rd(8'h00);
		`CHK(d, 32'h00000000)
		rd(8'h04);
		`CHK(d, 32'h00000063)
		rd(8'hf0);
		`CHK({r, d}, {2'h2, 32'h00000000})
	endtask
	task automatic t_default;
		runCmd <= 1'h1;
		tick(3);
		`CHK({collectorOut, colLevel}, 2'h2)
		dcBrake <= 1'h1;
		tick(3);
		`CHK(collectorOut, 1'h0)
		dcBrake <= 1'h0;
		faultTrip <= 1'h1;
		tick(1);
		faultTrip <= 1'h0;
		tick(8);
		`CHK({relayOut, relayContact}, 2'h3)
		faultReset <= 1'h1;
		tick(1);
		faultReset <= 1'h0;
		tick(3);
		`CHK(relayOut, 1'h0)
	endtask
	// Pulse source may never land on the relay, either polarity
	task automatic t_relay;
		logic [31:0] c[2] = '{32'h0000005d, 32'h000000c1};
		for (int i = 0; i < 2; i++) begin
			wr(8'h04, c[i]);
			`CHK(r, 2'h2)
			rd(8'h04);
			`CHK(d, 32'h00000063)
		end
		rd(8'h34);
		`CHK(d[22], 1'h1)
		rd(8'h34);
		`CHK(d[22], 1'h0)
	endtask
	task automatic t_codes;
		logic [31:0] c[8] = '{32'h03, 32'h40, 32'h46, 32'h5b, 32'h0e, 32'h0f, 32'h10, 32'h2e};
		wr(8'h00, 32'h0000000b);
		tick(2);
		`CHK(collectorOut, 1'h1)
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, c[i]);
			flagIn[i] <= 1'h1;
			tick(4);
			`CHK(collectorOut, 1'h1)
			wr(8'h00, c[i] + 32'h00000064);
			tick(2);
			`CHK(collectorOut, 1'h0)
			flagIn[i] <= 1'h0;
		end
		wr(8'h00, 32'h0000002e);
		tick(2);
		`CHK(collectorOut, 1'h1)
		faultReset <= 1'h1;
		tick(1);
		faultReset <= 1'h0;
		tick(3);
		`CHK(collectorOut, 1'h0)
		wr(8'h00, 32'h0000270f);
		tick(2);
		`CHK(collectorOut, 1'h0)
	endtask
	task automatic t_levels;
		wr(8'h20, 32'h00000064);
		wr(8'h24, 32'h00000003);
		wr(8'h00, 32'h0000000c);
		outCurrent <= 16'h00c8;
		tick(3);
		`CHK(collectorOut, 1'h0)
		tick(4);
		`CHK(collectorOut, 1'h1)
		wr(8'h1c, 32'h00000064);
		wr(8'h00, 32'h00000008);
		thermalAcc <= 16'h0054;
		tick(3);
		`CHK(collectorOut, 1'h0)
		thermalAcc <= 16'h0055;
		tick(3);
		`CHK({collectorOut, thermalTrip}, 2'h2)
		thermalAcc <= 16'h0064;
		tick(3);
		`CHK(thermalTrip, 1'h1)
		wr(8'h00, 32'h0000001a);
		heatsinkTemp <= 16'h0055;
		tick(3);
		`CHK(collectorOut, 1'h1)
	endtask
	// Threshold flags; the reverse threshold counts only while reversing
	task automatic t_detect;
		wr(8'h14, 32'h00000030);
		wr(8'h00, 32'h00000004);
		tick(2);
		`CHK(collectorOut, 1'h0)
		reverseRun <= 1'h1;
		tick(3);
		`CHK(collectorOut, 1'h1)
		reverseRun <= 1'h0;
		wr(8'h18, 32'h00000064);
		wr(8'h00, 32'h00000007);
		brakeDuty <= 16'h0054;
		tick(3);
		`CHK(collectorOut, 1'h0)
		brakeDuty <= 16'h0055;
		tick(3);
		`CHK(collectorOut, 1'h1)
		wr(8'h00, 32'h00000001);
		outFreq <= 16'h0030;
		tick(3);
		`CHK(collectorOut, 1'h0)
		outFreq <= 16'h003a;
		tick(3);
		`CHK(collectorOut, 1'h1)
		outFreq <= 16'h0040;
		wr(8'h30, 32'h00000002);
		wr(8'h00, 32'h0000005f);
		tick(2);
		`CHK(collectorOut, 1'h0)
		wr(8'h30, 32'h00000001);
		tick(2);
		`CHK(collectorOut, 1'h1)
		wr(8'h2c, 32'h00000002);
		wr(8'h00, 32'h0000000d);
		tick(2);
		`CHK(collectorOut, 1'h1)
		wr(8'h28, 32'h00000000);
		tick(2);
		`CHK(collectorOut, 1'h0)
	endtask
	// Two unit runs of 4 cycles: current high 8, maintenance high 4
	task automatic t_pulse;
		int h[2];
		int n;
		wr(8'h00, 32'h0000005d);
		`CHK(r, 2'h0)
		n = 0;
		for (int k = 0; k < 2; k++) begin
			while (collectorOut && n < 200) begin tick(1); n++; end
			while (!collectorOut && n < 200) begin tick(1); n++; end
			h[k] = 0;
			while (collectorOut && h[k] < 200) begin tick(1); h[k]++; end
		end
		`CHK({h[0] + h[1], h[0] != h[1]}, {32'd12, 1'b1})
	endtask
	// ****************************************
	// Clock, reset, sequence and watchdog
	// ****************************************
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		{rst, resetDone, startPossible, pidActive} = 4'hf;
		{runCmd, dcBrake, faultTrip, faultReset, flagIn} = 12'h000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{outFreq, thermalAcc, heatsinkTemp, outCurrent} = {16'h0040, 48'h0};
		{avgCurrent, maintTimer} = {16'h0002, 16'h0001};
		{reverseRun, brakeDuty} = 17'h00000;
		tick(5);
		rst <= 1'h0;
		tick(1);
		t_reset;
		t_default;
		t_relay;
		t_codes;
		t_levels;
		t_detect;
		t_pulse;
		report_and_stop;
	end
	initial begin
		tick(20000);
		errors++;
		report_and_stop;
	end
endmodule

// [sim/ots_selector_sva.sv]
// Checker of bus handshakes and of terminal routing at reset selects
module ots_selector_sva (
	input logic        mclk,
	input logic        rst,
	input logic [15:0] outFreq,
	input logic        runCmd,
	input logic        dcBrake,
	input logic        faultTrip,
	input logic        faultReset,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        collectorOut,
	input logic        relayOut
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic defCfg_ff;
	logic quiet;
	// Any write may move a select, so reset routing is trusted only before one
	always @(posedge mclk) begin
		if (rst)
			defCfg_ff <= 1'h1;
		else if (s_axi_awvalid)
			defCfg_ff <= 1'h0;
	end
	assign quiet = defCfg_ff && !s_axi_awvalid;
	sequence sWrTaken;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	endsequence
	sequence sWrAnswer;
		s_axi_awready && s_axi_wready && s_axi_bvalid;
	endsequence
	a_write_answer: assert property (sWrTaken |=> sWrAnswer)
		else $error("Write not answered one cycle after taking");
	a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("Write ready held longer than one cycle");
	a_bresp_cause: assert property ($rose(s_axi_bvalid) |-> s_axi_awready)
		else $error("Write response without a taken address");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("Write response dropped before ready");
	a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
		|=> s_axi_arready && s_axi_rvalid)
		else $error("Read not answered one cycle after taking");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data moved before ready");
	a_run_on: assert property (quiet && !$past(rst) && runCmd && !dcBrake
		&& outFreq >= 16'h0032 |=> collectorOut)
		else $error("Collector off while running");
	a_run_off: assert property (quiet && !$past(rst) && (!runCmd || dcBrake)
		|=> !collectorOut)
		else $error("Collector on while stopped or braking");
	a_fault_set: assert property (quiet && !$past(rst) && faultTrip |-> ##[1:2] relayOut)
		else $error("Relay not energised after fault");
	a_fault_hold: assert property (quiet && relayOut && !faultReset
		&& !$past(faultReset) |=> relayOut)
		else $error("Relay released without fault reset");
endmodule

bind ots_selector ots_selector_sva ots_selector_sva_inst (.mclk, .rst, .outFreq, .runCmd,
	.dcBrake, .faultTrip, .faultReset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .collectorOut, .relayOut);

// [verilog/ots_regs.vh]
// Register offsets, reset values and function codes of the output terminal selector
`ifndef OTS_REGS_VH
`define OTS_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OTS_OFF_COLSEL   8'h00
`define OTS_OFF_RLYSEL   8'h04
`define OTS_OFF_STARTF   8'h08
`define OTS_OFF_SENS     8'h0c
`define OTS_OFF_DETF     8'h10
`define OTS_OFF_REVDETF  8'h14
`define OTS_OFF_BRKLIM   8'h18
`define OTS_OFF_THTRIP   8'h1c
`define OTS_OFF_OCLVL    8'h20
`define OTS_OFF_OCTIME   8'h24
`define OTS_OFF_LPLVL    8'h28
`define OTS_OFF_LPTIME   8'h2c
`define OTS_OFF_MAINT    8'h30
`define OTS_OFF_STATUS   8'h34
`define OTS_NUM_CFG      14

// ****************************************
// Reset values
// ****************************************
`define OTS_RST_COLSEL   16'h0000
`define OTS_RST_RLYSEL   16'h0063
`define OTS_RST_STARTF   16'h0032
`define OTS_RST_SENS     16'h000a
`define OTS_RST_DETF     16'h0258
`define OTS_RST_REVDETF  16'h270f
`define OTS_RST_OTHER    16'hffff

// ****************************************
// Function codes and limits
// ****************************************
`define OTS_CODE_NONE    16'h270f
`define OTS_CODE_PULSE   7'h5d
`define OTS_NEG_BASE     16'h0064
`define OTS_NEG_END      16'h00c8
`define OTS_PREWARN_PCT  32'h00000055
`define OTS_FULL_PCT     32'h00000064

// ****************************************
// Bus responses
// ****************************************
`define OTS_RESP_OKAY    2'b00
`define OTS_RESP_SLVERR  2'b10

`endif

// [verilog/ots_selector.v]
// Output terminal selector: status flags, code routing and AXI4-Lite register file
// Overview of operation
// - Collector select code resets to 0
// - Relay select code resets to 99
// - Codes 100-199 route same signal inverted
// - Relay select rejects 93 and 193
// - Output-active when frequency at/above start
// - At-speed within sensitivity band of set
// - Stall-limit follows stall prevention activity
// - Frequency threshold, optional reverse threshold
// - Brake pre-warn at 85% of limit
// - Thermal pre-warn 85%, trip at 100%
// - Ready after reset, while startable or running and no fault latched
// - Overcurrent after level exceeded beyond time
// - Low power after level undercut beyond time
// - PID low, high and forward flags
// - Heatsink pre-warn at 85% of limit
// - Power-loss decel flag latched until release
// - Retry flag during retry processing
// - PID pause flag during interruption
// - Internal fault flag on circuit fault
// - Code 93 emits current/maintenance pulses
// - Maintenance flag when timer reaches threshold
// - Fault relay flag held until reset
// - Positive conducts when active, negative not
// - Output-active off when stopped or braking
`include "ots_regs.vh"

module ots_selector #(
	parameter PULSE_UNIT = 16'd1000
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire [15:0] outFreq,
	input  wire [15:0] setFreq,
	input  wire        runCmd,
	input  wire        reverseRun,
	input  wire        dcBrake,
	input  wire        stallActive,
	input  wire [15:0] brakeDuty,
	input  wire [15:0] thermalAcc,
	input  wire [15:0] heatsinkTemp,
	input  wire [15:0] heatsinkLimit,
	input  wire [15:0] outCurrent,
	input  wire [15:0] outPower,
	input  wire        pidActive,
	input  wire        feedbackLow,
	input  wire        feedbackHigh,
	input  wire        pidForward,
	input  wire        pidPause,
	input  wire        powerlossDecel,
	input  wire        powerlossRelease,
	input  wire        retryActive,
	input  wire        internalFault,
	input  wire        faultTrip,
	input  wire        faultReset,
	input  wire        resetDone,
	input  wire        startPossible,
	input  wire [15:0] avgCurrent,
	input  wire [15:0] maintTimer,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire        collectorOut,
	output wire        relayOut,
	output wire        thermalTrip
);

	// ****************************************
	// Functions
	// ****************************************

	// Legal select codes; the relay cannot carry the pulse train
	function validCode;
		input [15:0] code;
		input        isRelay;
		begin
			case (code)
				16'd0, 16'd1, 16'd3, 16'd4, 16'd7, 16'd8, 16'd11, 16'd12, 16'd13,
				16'd14, 16'd15, 16'd16, 16'd25, 16'd26, 16'd46, 16'd47, 16'd64,
				16'd70, 16'd90, 16'd91, 16'd95, 16'd96, 16'd98, 16'd99,
				16'd100, 16'd101, 16'd103, 16'd104, 16'd107, 16'd108, 16'd111,
				16'd112, 16'd113, 16'd114, 16'd115, 16'd116, 16'd125, 16'd126,
				16'd146, 16'd147, 16'd164, 16'd170, 16'd190, 16'd191, 16'd195,
				16'd196, 16'd198, 16'd199, 16'd9999: validCode = 1'b1;
				16'd93, 16'd193: validCode = ~isRelay;
				default: validCode = 1'b0;
			endcase
		end
	endfunction

	// Code to terminal level; 1 means the terminal conducts
	function routeCode;
		input [15:0] code;
		input [99:0] fv;
		input        pulse;
		reg   [15:0] base;
		reg          inv;
		begin
			base = code;
			inv = 1'b0;
			routeCode = 1'b0;
			if (code >= `OTS_NEG_BASE && code < `OTS_NEG_END) begin
				base = code - `OTS_NEG_BASE;
				inv = 1'b1;
			end
			if (code == `OTS_CODE_NONE) begin
				routeCode = 1'b0;
			end else if (base[6:0] == `OTS_CODE_PULSE) begin
				routeCode = pulse ^ inv;
			end else if (base < 16'd100) begin
				routeCode = fv[base[6:0]] ^ inv;
			end
		end
	endfunction

	// Value at or above pct percent of a limit
	function atPct;
		input [15:0] value;
		input [15:0] limit;
		input [31:0] pct;
		reg   [31:0] lhs;
		reg   [31:0] rhs;
		begin
			lhs = {16'h0000, value} * `OTS_FULL_PCT;
			rhs = {16'h0000, limit} * pct;
			atPct = (lhs >= rhs);
		end
	endfunction

	// ****************************************
	// Configuration storage and bus state
	// ****************************************
	reg  [15:0] cfg_ff [0:`OTS_NUM_CFG-1];
	reg         awReady_ff;
	reg         wReady_ff;
	reg         bValid_ff;
	reg  [1:0]  bResp_ff;
	reg         arReady_ff;
	reg         rValid_ff;
	reg  [31:0] rData_ff;
	reg  [1:0]  rResp_ff;
	reg         badWrite_ff;
	reg         nxt_badWrite;

	wire [3:0]  wIdx = s_axi_awaddr[5:2];
	wire [3:0]  rIdx = s_axi_araddr[5:2];
	wire        wHit = (s_axi_awaddr[7:6] == 2'b00) && (wIdx < 4'd13);
	wire        rHit = (s_axi_araddr[7:6] == 2'b00) && (rIdx < 4'd14);
	wire        wTake = s_axi_awvalid && s_axi_wvalid && !bValid_ff
		&& !awReady_ff;
	wire        rTake = s_axi_arvalid && !rValid_ff && !arReady_ff;
	wire [15:0] wVal = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : cfg_ff[wIdx][15:8],
		s_axi_wstrb[0] ? s_axi_wdata[7:0] : cfg_ff[wIdx][7:0]};
	wire        selIdx = (wIdx == 4'd0) || (wIdx == 4'd1);
	wire        selOk = validCode(wVal, wIdx == 4'd1);
	wire        wOk = wHit && (!selIdx || selOk);

	// Flag state
	reg         faultRelay_ff;
	reg         powerloss_ff;
	reg         readySeen_ff;
	reg  [15:0] ocCnt_ff;
	reg  [15:0] lpCnt_ff;
	reg         collector_ff;
	reg         relay_ff;
	reg         thermalTrip_ff;
	reg  [99:0] flagVec;
	reg  [31:0] statusWord;

	// ****************************************
	// Register writes
	// ****************************************

	// Illegal select codes keep the old value and answer SLVERR
	integer i;
	always @(posedge mclk) begin
		if (rst) begin
			for (i = 0; i < `OTS_NUM_CFG; i = i + 1) begin
				cfg_ff[i] <= `OTS_RST_OTHER;
			end
			cfg_ff[0] <= `OTS_RST_COLSEL;
			cfg_ff[1] <= `OTS_RST_RLYSEL;
			cfg_ff[2] <= `OTS_RST_STARTF;
			cfg_ff[3] <= `OTS_RST_SENS;
			cfg_ff[4] <= `OTS_RST_DETF;
			cfg_ff[5] <= `OTS_RST_REVDETF;
		end else if (wTake && wOk) begin
			cfg_ff[wIdx] <= wVal;
		end
	end

	// Write channel handshake, both channels taken in one cycle
	always @(posedge mclk) begin
		if (rst) begin
			awReady_ff <= 1'b0;
			wReady_ff <= 1'b0;
			bValid_ff <= 1'b0;
			bResp_ff <= `OTS_RESP_OKAY;
			badWrite_ff <= 1'b0;
		end else begin
			awReady_ff <= wTake;
			wReady_ff <= wTake;
			badWrite_ff <= nxt_badWrite;
			if (wTake) begin
				bValid_ff <= 1'b1;
				bResp_ff <= wOk ? `OTS_RESP_OKAY : `OTS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bValid_ff <= 1'b0;
			end
		end
	end

	// Sticky record of a refused select code, cleared by status read
	always @* begin
		nxt_badWrite = badWrite_ff;
		if (rTake && rHit && rIdx == 4'd13) begin
			nxt_badWrite = 1'b0;
		end
		if (wTake && wHit && selIdx && !selOk) begin
			nxt_badWrite = 1'b1; // Set wins over the clear
		end
	end

	// ****************************************
	// Register reads
	// ****************************************

	// Read data is captured when the address is taken
	always @(posedge mclk) begin
		if (rst) begin
			arReady_ff <= 1'b0;
			rValid_ff <= 1'b0;
			rData_ff <= 32'h00000000;
			rResp_ff <= `OTS_RESP_OKAY;
		end else begin
			arReady_ff <= rTake;
			if (rTake) begin
				rValid_ff <= 1'b1;
				rResp_ff <= rHit ? `OTS_RESP_OKAY : `OTS_RESP_SLVERR;
				if (!rHit) begin
					rData_ff <= 32'h00000000;
				end else if (rIdx == 4'd13) begin
					rData_ff <= statusWord;
				end else begin
					rData_ff <= {16'h0000, cfg_ff[rIdx]};
				end
			end else if (s_axi_rready) begin
				rValid_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Status flag conditions
	// ****************************************
	wire [15:0] freqDiff = (outFreq > setFreq) ? outFreq - setFreq
		: setFreq - outFreq;
	wire [31:0] diffPct = {16'h0000, freqDiff} * `OTS_FULL_PCT;
	wire [31:0] bandPct = {16'h0000, setFreq} * {16'h0000, cfg_ff[3]};
	wire [15:0] detThr = (reverseRun && cfg_ff[5] != `OTS_CODE_NONE)
		? cfg_ff[5] : cfg_ff[4];
	wire        runFlag = runCmd && !dcBrake && (outFreq >= cfg_ff[2]);
	wire        ocFlag = (ocCnt_ff > cfg_ff[9]);
	wire        lpFlag = (lpCnt_ff > cfg_ff[11]);
	wire        pulseOut;

	// Output current above level and output power below level, counted in clock cycles
	always @(posedge mclk) begin
		if (rst) begin
			ocCnt_ff <= 16'h0000;
			lpCnt_ff <= 16'h0000;
		end else begin
			if (outCurrent <= cfg_ff[8]) begin
				ocCnt_ff <= 16'h0000;
			end else if (ocCnt_ff != 16'hffff) begin
				ocCnt_ff <= ocCnt_ff + 16'h0001;
			end
			if (outPower >= cfg_ff[10]) begin
				lpCnt_ff <= 16'h0000;
			end else if (lpCnt_ff != 16'hffff) begin
				lpCnt_ff <= lpCnt_ff + 16'h0001;
			end
		end
	end

	// Latched flags and the registered thermal trip, which follows thermalAcc each cycle; a new event wins over its own clear
	always @(posedge mclk) begin
		if (rst) begin
			faultRelay_ff <= 1'b0;
			powerloss_ff <= 1'b0;
			readySeen_ff <= 1'b0;
			thermalTrip_ff <= 1'b0;
		end else begin
			if (faultTrip) begin
				faultRelay_ff <= 1'b1;
			end else if (faultReset) begin
				faultRelay_ff <= 1'b0;
			end
			if (powerlossDecel) begin
				powerloss_ff <= 1'b1;
			end else if (powerlossRelease) begin
				powerloss_ff <= 1'b0;
			end
			if (resetDone) begin
				readySeen_ff <= 1'b1;
			end
			thermalTrip_ff <= atPct(thermalAcc, cfg_ff[7], `OTS_FULL_PCT);
		end
	end

	// Flag vector indexed by positive code
	always @* begin
		flagVec = 100'h0;
		flagVec[0] = runFlag;
		flagVec[1] = (diffPct <= bandPct);
		flagVec[3] = stallActive;
		flagVec[4] = (outFreq >= detThr);
		flagVec[7] = atPct(brakeDuty, cfg_ff[6], `OTS_PREWARN_PCT);
		flagVec[8] = atPct(thermalAcc, cfg_ff[7], `OTS_PREWARN_PCT);
		flagVec[11] = readySeen_ff && !faultRelay_ff
			&& (startPossible || runFlag);
		flagVec[12] = ocFlag;
		flagVec[13] = lpFlag;
		flagVec[14] = pidActive && feedbackLow;
		flagVec[15] = pidActive && feedbackHigh;
		flagVec[16] = pidActive && pidForward;
		flagVec[26] = atPct(heatsinkTemp, heatsinkLimit, `OTS_PREWARN_PCT);
		flagVec[46] = powerloss_ff;
		flagVec[47] = pidActive;
		flagVec[64] = retryActive;
		flagVec[70] = pidActive && pidPause;
		flagVec[91] = internalFault;
		flagVec[95] = (maintTimer >= cfg_ff[12]);
		flagVec[99] = faultRelay_ff;
	end

	// Status word: flags, terminals and refused-write record
	always @* begin
		statusWord = {9'h000, badWrite_ff, relay_ff, collector_ff, thermalTrip_ff,
			flagVec[99], flagVec[95], flagVec[91], flagVec[70], flagVec[64],
			flagVec[46], flagVec[26], flagVec[16], flagVec[15], flagVec[14],
			flagVec[13], flagVec[12], flagVec[11], flagVec[8], flagVec[7],
			flagVec[4], flagVec[3], flagVec[1], flagVec[0]};
	end

	// ****************************************
	// Current and maintenance pulse train
	// ****************************************
	localparam PH_CUR  = 2'd0;
	localparam PH_GAP1 = 2'd1;
	localparam PH_MNT  = 2'd2;
	localparam PH_GAP2 = 2'd3;

	reg  [1:0]  phase_ff;
	reg  [15:0] unitCnt_ff;
	reg  [15:0] left_ff;
	reg         pulse_ff;

	// High for avgCurrent units, gap, high for maintTimer units, gap
	always @(posedge mclk) begin
		if (rst) begin
			phase_ff <= PH_GAP2;
			unitCnt_ff <= 16'h0000;
			left_ff <= 16'h0001;
			pulse_ff <= 1'b0;
		end else if (unitCnt_ff != PULSE_UNIT - 16'd1) begin
			unitCnt_ff <= unitCnt_ff + 16'h0001;
		end else begin
			unitCnt_ff <= 16'h0000;
			if (left_ff > 16'h0001) begin
				left_ff <= left_ff - 16'h0001;
			end else begin
				case (phase_ff)
					PH_GAP2: begin
						phase_ff <= PH_CUR;
						left_ff <= (avgCurrent == 16'h0000) ? 16'h0001 : avgCurrent;
						pulse_ff <= (avgCurrent != 16'h0000);
					end
					PH_CUR: begin
						phase_ff <= PH_GAP1;
						left_ff <= 16'h0001;
						pulse_ff <= 1'b0;
					end
					PH_GAP1: begin
						phase_ff <= PH_MNT;
						left_ff <= (maintTimer == 16'h0000) ? 16'h0001 : maintTimer;
						pulse_ff <= (maintTimer != 16'h0000);
					end
					default: begin
						phase_ff <= PH_GAP2;
						left_ff <= 16'h0001;
						pulse_ff <= 1'b0;
					end
				endcase
			end
		end
	end
	assign pulseOut = pulse_ff;

	// ****************************************
	// Terminal drivers
	// ****************************************

	// Registered so the pins never glitch on code changes
	always @(posedge mclk) begin
		if (rst) begin
			collector_ff <= 1'b0;
			relay_ff <= 1'b0;
		end else begin
			collector_ff <= routeCode(cfg_ff[0], flagVec, pulseOut);
			relay_ff <= routeCode(cfg_ff[1], flagVec, 1'b0);
		end
	end

	assign collectorOut = collector_ff;
	assign relayOut = relay_ff;
	assign thermalTrip = thermalTrip_ff;
	assign s_axi_awready = awReady_ff;
	assign s_axi_wready = wReady_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign s_axi_arready = arReady_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;

endmodule
